// ---- rtl/dip_defines.svh ----
// Offsets, field positions, reset values and timing counts for the drive input image packer.
// Assumes inclusion by bare name from the package and the packer module.
`ifndef DIP_DEFINES_SVH
`define DIP_DEFINES_SVH

// ==========================================================
// Image layout, byte offsets of each field
`define DIP_IMG_BYTES      56
`define DIP_OFS_ROUT       0
`define DIP_OFS_OPSEL      2
`define DIP_OFS_FIXED      4
`define DIP_OFS_ALARM      6
`define DIP_OFS_FBPOS      8
`define DIP_OFS_FBSPD      12
`define DIP_OFS_CMDPOS     16
`define DIP_OFS_TORQUE     20
`define DIP_OFS_CSTCUR     22
`define DIP_OFS_NOTICE     24
`define DIP_OFS_RSV        28
`define DIP_OFS_RDID       30
`define DIP_OFS_RWSTAT     32
`define DIP_OFS_WRID       34
`define DIP_OFS_RDDATA     36
`define DIP_OFS_MON0       40

// ==========================================================
// Fixed output word bit positions
`define DIP_FX_SEQ         0
`define DIP_FX_MOVE        1
`define DIP_FX_INPOS       2
`define DIP_FX_START       3
`define DIP_FX_HOME        4
`define DIP_FX_READY       5
`define DIP_FX_DACC        6
`define DIP_FX_ALARM       7
`define DIP_FX_TRIG        8
`define DIP_FX_TRIGK       9
`define DIP_FX_SETERR      10
`define DIP_FX_EXEERR      11
`define DIP_FX_BUFW        12
`define DIP_FX_STOP        13
`define DIP_FX_TOFF        14
`define DIP_FX_TLIM        15

// ==========================================================
// Register byte addresses
`define DIP_REG_CTRL       8'h00
`define DIP_REG_RPI        8'h04
`define DIP_REG_STAT       8'h08
`define DIP_REG_MAP_BASE   8'h40
`define DIP_REG_MAP_LAST   8'h7C

// ==========================================================
// Reset values and interval limits
`define DIP_CTRL_RST       1'b1
`define DIP_RPI_RST        12'h00A
`define DIP_RPI_MIN        12'h001
`define DIP_RPI_MAX        12'hC80
`define DIP_MAP_RST        {8'h8C, 8'h8A, 8'h86, 8'h9D, 8'hA2, 8'hA1, 8'hA0, 8'h88, \
                            8'h81, 8'h87, 8'h84, 8'h90, 8'h20, 8'h42, 8'h41, 8'h40}

// ==========================================================
// Timing
`define DIP_CLK_PERIOD_NS  100
`define DIP_RPI_UNIT_NS    1000000

`endif

// ---- rtl/dip_pkg.sv ----
// Types shared by the drive input image packer.
// Assumes the image layout header is on the include path.
`include "dip_defines.svh"

package dip_pkg;

	// Drive state sampled into one image, all on the system clock
	typedef struct packed {
		logic [7:0]       op_select;
		logic [15:0]      alarm_code;
		logic [31:0]      fb_pos;
		logic [31:0]      fb_speed;
		logic [31:0]      cmd_pos;
		logic [15:0]      torque_mon;
		logic [15:0]      cst_current;
		logic [31:0]      notice_code;
		logic [15:0]      rd_id_echo;
		logic [15:0]      rw_status;
		logic [15:0]      wr_id_echo;
		logic [31:0]      rd_data;
		logic [3:0][31:0] monitor;
		logic             stored_sequence_running;
		logic             moving;
		logic             in_position;
		logic             start_echo;
		logic             homing_done;
		logic             preset_done;
		logic             ready;
		logic             direct_op_accept;
		logic             alarm_flag;
		logic             trigger_echo;
		logic             trigger_kind_echo;
		logic [6:0]       direct_set_err;
		logic             direct_execute_fault;
		logic             direct_buffer_writing;
		logic             stop_echo;
		logic             torque_off_active;
		logic             torque_limited;
	} dip_drv_state_t;

	typedef enum logic {
		DIP_ST_IDLE,
		DIP_ST_SEND
	} dip_state_t;

endpackage : dip_pkg

// ---- rtl/dip_packer.sv ----
// Drive input image packer: builds the 56-byte cyclic image and streams it byte by byte.
// Assumes drive state and the byte sink run on clk_sys; software reaches it over classic Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "dip_defines.svh"

module dip_packer #(
	parameter int CYCLES_PER_MS = `DIP_RPI_UNIT_NS / `DIP_CLK_PERIOD_NS
) (
	input  wire logic                    clk_sys,
	input  wire logic                    rst_b,
	// Classic Wishbone slave
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	input  wire logic                    wb_we_i,
	input  wire logic [7:0]              wb_adr_i,
	input  wire logic [3:0]              wb_sel_i,
	input  wire logic [31:0]             wb_dat_i,
	output logic      [31:0]             wb_dat_o,
	output logic                         wb_ack_o,
	// Drive state
	input  wire dip_pkg::dip_drv_state_t drv_state,
	input  wire logic [255:0]            sig_pool,
	// Image byte stream toward the transport
	output logic                         tx_valid,
	input  wire logic                    tx_ready,
	output logic      [7:0]              tx_byte,
	output logic                         tx_first,
	output logic                         tx_last
);

	localparam int IMG_BITS = `DIP_IMG_BYTES * 8;
	localparam logic [5:0] LAST_IDX = 6'(`DIP_IMG_BYTES - 1);

	// ==========================================================
	// Parameter check
	if (CYCLES_PER_MS < 1) begin : g_bad_rate
		$error("CYCLES_PER_MS must be at least one");
	end

	// ==========================================================
	// Functions

	// Byte-lane mask from Wishbone select
	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction : lane_mask

	// True when the address hits one of the sixteen remote map words
	function automatic logic is_map(input logic [7:0] adr);
		is_map = (adr >= `DIP_REG_MAP_BASE) && (adr <= `DIP_REG_MAP_LAST) && (adr[1:0] == 2'b00);
	endfunction : is_map

	// Hardwired fixed output word; no register can touch it
	function automatic logic [15:0] fixed_word(input dip_pkg::dip_drv_state_t s);
		logic [15:0] w;
		w = 16'h0000;
		w[`DIP_FX_SEQ]    = s.stored_sequence_running;
		w[`DIP_FX_MOVE]   = s.moving;
		w[`DIP_FX_INPOS]  = s.in_position;
		w[`DIP_FX_START]  = s.start_echo;
		w[`DIP_FX_HOME]   = s.homing_done | s.preset_done;
		w[`DIP_FX_READY]  = s.ready;
		w[`DIP_FX_DACC]   = s.direct_op_accept;
		w[`DIP_FX_ALARM]  = s.alarm_flag;
		w[`DIP_FX_TRIG]   = s.trigger_echo;
		w[`DIP_FX_TRIGK]  = s.trigger_kind_echo;
		w[`DIP_FX_SETERR] = |s.direct_set_err;
		w[`DIP_FX_EXEERR] = s.direct_execute_fault;
		w[`DIP_FX_BUFW]   = s.direct_buffer_writing;
		w[`DIP_FX_STOP]   = s.stop_echo;
		w[`DIP_FX_TOFF]   = s.torque_off_active;
		w[`DIP_FX_TLIM]   = s.torque_limited;
		fixed_word = w;
	endfunction : fixed_word

	// Whole image; byte n lands at bits 8n, so shifting right sends LSB first
	function automatic logic [IMG_BITS-1:0] build_image(input dip_pkg::dip_drv_state_t s,
		input logic [15:0] rout);
		logic [IMG_BITS-1:0] img;
		img = '0;
		img[`DIP_OFS_ROUT*8   +: 16] = rout;
		img[`DIP_OFS_OPSEL*8  +: 16] = {8'h00, s.op_select};
		img[`DIP_OFS_FIXED*8  +: 16] = fixed_word(s);
		img[`DIP_OFS_ALARM*8  +: 16] = s.alarm_code;
		img[`DIP_OFS_FBPOS*8  +: 32] = s.fb_pos;
		img[`DIP_OFS_FBSPD*8  +: 32] = s.fb_speed;
		img[`DIP_OFS_CMDPOS*8 +: 32] = s.cmd_pos;
		img[`DIP_OFS_TORQUE*8 +: 16] = s.torque_mon;
		img[`DIP_OFS_CSTCUR*8 +: 16] = s.cst_current;
		img[`DIP_OFS_NOTICE*8 +: 32] = s.notice_code;
		img[`DIP_OFS_RSV*8    +: 16] = 16'h0000;
		img[`DIP_OFS_RDID*8   +: 16] = s.rd_id_echo;
		img[`DIP_OFS_RWSTAT*8 +: 16] = s.rw_status;
		img[`DIP_OFS_WRID*8   +: 16] = s.wr_id_echo;
		img[`DIP_OFS_RDDATA*8 +: 32] = s.rd_data;
		for (int m = 0; m < 4; m++) begin
			img[(`DIP_OFS_MON0 + 4*m)*8 +: 32] = s.monitor[m];
		end
		build_image = img;
	endfunction : build_image

	// ==========================================================
	// Remote output word: each bit picks its signal from the pool
	logic [15:0][7:0] map_q;
	logic [15:0][7:0] map_d;
	logic [15:0]      rout;

	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_rout
			assign rout[gi] = sig_pool[map_q[gi]];
		end
	endgenerate

	// ==========================================================
	// Register file state
	logic        ctrl_en_q;
	logic        ctrl_en_d;
	logic [11:0] rpi_q;
	logic [11:0] rpi_d;
	logic        ack_q;
	logic        ack_d;
	logic [31:0] rdat_q;
	logic [31:0] rdat_d;
	logic [15:0] frames_q;
	logic [15:0] frames_d;
	logic [15:0] late_q;
	logic [15:0] late_d;

	// ==========================================================
	// Interval timer state
	logic [31:0] ms_cnt_q;
	logic [31:0] ms_cnt_d;
	logic [11:0] rpi_cnt_q;
	logic [11:0] rpi_cnt_d;
	logic        tick;

	// ==========================================================
	// Framer state
	dip_pkg::dip_state_t   st_q;
	dip_pkg::dip_state_t   st_d;
	logic [IMG_BITS-1:0]   shift_q;
	logic [IMG_BITS-1:0]   shift_d;
	logic [5:0]            idx_q;
	logic [5:0]            idx_d;
	logic                  sending;

	assign sending = (st_q == dip_pkg::DIP_ST_SEND);

	// ==========================================================
	// Wishbone slave: ack one cycle after the request, dropped the cycle after.
	// Writes land only at the edge where the master sees ack, so a stretched request cannot write twice.
	always_comb begin
		logic [31:0] m;
		logic [31:0] w;
		m         = lane_mask(wb_sel_i);
		ctrl_en_d = ctrl_en_q;
		rpi_d     = rpi_q;
		map_d     = map_q;
		ack_d     = wb_cyc_i && wb_stb_i && !ack_q;
		rdat_d    = rdat_q;
		w         = 32'h0000_0000;
		if (wb_cyc_i && wb_stb_i && wb_we_i && ack_q) begin
			if (wb_adr_i == `DIP_REG_CTRL && wb_sel_i[0]) begin
				ctrl_en_d = wb_dat_i[0];
			end else if (wb_adr_i == `DIP_REG_RPI) begin
				w = ({20'h0_0000, rpi_q} & ~m) | (wb_dat_i & m);
				// Out-of-range intervals clamp so the timer never stalls
				if (w[31:0] < 32'(`DIP_RPI_MIN)) begin
					rpi_d = `DIP_RPI_MIN;
				end else if (w[31:0] > 32'(`DIP_RPI_MAX)) begin
					rpi_d = `DIP_RPI_MAX;
				end else begin
					rpi_d = w[11:0];
				end
			end else if (is_map(wb_adr_i) && wb_sel_i[0]) begin
				map_d[wb_adr_i[5:2]] = wb_dat_i[7:0];
			end
		end
		if (ack_d && !wb_we_i) begin
			if (wb_adr_i == `DIP_REG_CTRL) begin
				rdat_d = {31'h0000_0000, ctrl_en_q};
			end else if (wb_adr_i == `DIP_REG_RPI) begin
				rdat_d = {20'h0_0000, rpi_q};
			end else if (wb_adr_i == `DIP_REG_STAT) begin
				rdat_d = {frames_q, late_q[14:0], sending};
			end else if (is_map(wb_adr_i)) begin
				rdat_d = {24'h00_0000, map_q[wb_adr_i[5:2]]};
			end else begin
				rdat_d = 32'h0000_0000;                                        // Unmapped reads zero
			end
		end
	end

	// Register file flops
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_en_q <= `DIP_CTRL_RST;
			rpi_q     <= `DIP_RPI_RST;
			map_q     <= `DIP_MAP_RST;
			ack_q     <= 1'b0;
			rdat_q    <= 32'h0000_0000;
		end else begin
			ctrl_en_q <= ctrl_en_d;
			rpi_q     <= rpi_d;
			map_q     <= map_d;
			ack_q     <= ack_d;
			rdat_q    <= rdat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// ==========================================================
	// Interval timer: one tick per programmed number of milliseconds
	always_comb begin
		ms_cnt_d  = ms_cnt_q;
		rpi_cnt_d = rpi_cnt_q;
		tick      = 1'b0;
		if (!ctrl_en_q) begin
			ms_cnt_d  = 32'h0000_0000;
			rpi_cnt_d = 12'h000;
		end else if (ms_cnt_q >= 32'(CYCLES_PER_MS - 1)) begin
			ms_cnt_d = 32'h0000_0000;
			if (rpi_cnt_q + 12'h001 >= rpi_q) begin
				rpi_cnt_d = 12'h000;
				tick      = 1'b1;
			end else begin
				rpi_cnt_d = rpi_cnt_q + 12'h001;
			end
		end else begin
			ms_cnt_d = ms_cnt_q + 32'h0000_0001;
		end
	end

	// Timer flops
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ms_cnt_q  <= 32'h0000_0000;
			rpi_cnt_q <= 12'h000;
		end else begin
			ms_cnt_q  <= ms_cnt_d;
			rpi_cnt_q <= rpi_cnt_d;
		end
	end

	// ==========================================================
	// Framer: snapshot on tick, then shift out one byte per accepted beat.
	// A tick during a frame is counted as late and dropped; no second image is held.
	always_comb begin
		st_d     = st_q;
		shift_d  = shift_q;
		idx_d    = idx_q;
		frames_d = frames_q;
		late_d   = late_q;
		case (st_q)
			dip_pkg::DIP_ST_IDLE: begin
				if (tick) begin
					shift_d = build_image(drv_state, rout);
					idx_d   = 6'h00;
					st_d    = dip_pkg::DIP_ST_SEND;
				end
			end
			dip_pkg::DIP_ST_SEND: begin
				if (tick) begin
					late_d = late_q + 16'h0001;
				end
				if (tx_ready) begin
					shift_d = shift_q >> 8;
					idx_d   = idx_q + 6'h01;
					if (idx_q == LAST_IDX) begin
						st_d     = dip_pkg::DIP_ST_IDLE;
						frames_d = frames_q + 16'h0001;
					end
				end
			end
			default: begin
				st_d = dip_pkg::DIP_ST_IDLE;
			end
		endcase
	end

	// Framer flops
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st_q     <= dip_pkg::DIP_ST_IDLE;
			shift_q  <= '0;
			idx_q    <= 6'h00;
			frames_q <= 16'h0000;
			late_q   <= 16'h0000;
		end else begin
			st_q     <= st_d;
			shift_q  <= shift_d;
			idx_q    <= idx_d;
			frames_q <= frames_d;
			late_q   <= late_d;
		end
	end

	// Stream outputs; byte comes straight from the shift flops
	assign tx_valid = sending;
	assign tx_byte  = shift_q[7:0];
	assign tx_first = sending && (idx_q == 6'h00);
	assign tx_last  = sending && (idx_q == LAST_IDX);

	// ==========================================================
	// Assertions
	logic start_q;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			start_q <= 1'b0;
		end else begin
			start_q <= (st_q == dip_pkg::DIP_ST_IDLE) && tick;
		end
	end

	lsb_first_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		start_q |-> tx_byte == $past(rout[7:0]) && shift_q[`DIP_OFS_FBPOS*8 +: 8] == $past(drv_state.fb_pos[7:0]))
		else $error("feedback position low byte not first");

	rsv_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		start_q |-> shift_q[`DIP_OFS_RSV*8 +: 16] == 16'h0000 && shift_q[`DIP_OFS_OPSEL*8+8 +: 8] == 8'h00)
		else $error("reserved or echo upper byte not zero");

	rout_map_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		start_q |-> shift_q[0] == $past(sig_pool[map_q[0]]))
		else $error("remote bit 0 does not carry its mapped signal");

	alarm_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		start_q |-> shift_q[`DIP_OFS_FIXED*8 + `DIP_FX_ALARM] == $past(drv_state.alarm_flag))
		else $error("fixed alarm bit wrong");

	home_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		start_q |-> shift_q[`DIP_OFS_FIXED*8 + `DIP_FX_HOME] ==
			($past(drv_state.homing_done) | $past(drv_state.preset_done)))
		else $error("fixed home bit wrong");

	torque_pos_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		start_q |-> shift_q[`DIP_OFS_TORQUE*8 +: 16] == $past(drv_state.torque_mon))
		else $error("torque monitor misplaced");

	mon3_pos_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		start_q |-> shift_q[(`DIP_OFS_MON0+12)*8 +: 32] == $past(drv_state.monitor[3]))
		else $error("monitor 3 misplaced");

	frame_end_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		tx_valid && tx_ready && tx_last |=> !tx_valid && (idx_q == 6'(`DIP_IMG_BYTES)))
		else $error("frame did not end after byte 55");

	stall_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte) && $stable(idx_q))
		else $error("byte changed while stalled");

	rpi_range_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		rpi_q >= `DIP_RPI_MIN && rpi_q <= `DIP_RPI_MAX)
		else $error("interval out of range");

	bus_ack_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wb_cyc_i && wb_stb_i && !ack_q |=> ack_q ##1 !ack_q)
		else $error("bus answer not one cycle");

	frame_cov_c: cover property (@(posedge clk_sys) disable iff (!rst_b) tx_valid && tx_ready && tx_last);
	stall_cov_c: cover property (@(posedge clk_sys) disable iff (!rst_b) tx_valid && !tx_ready [*3]);
	late_cov_c:  cover property (@(posedge clk_sys) disable iff (!rst_b) sending && tick);
	remap_cov_c: cover property (@(posedge clk_sys) disable iff (!rst_b) ack_q && wb_we_i && is_map(wb_adr_i));

endmodule : dip_packer

`default_nettype wire

// ---- verif/dip_sink_model.sv ----
// Scanner-side byte sink for the input image stream: stores one frame of bytes.
// Assumes the packer streams on clk_sys; the bench picks the stall level.
`timescale 1ns/100ps
`default_nettype none

module dip_sink_model (
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	input  wire logic         tx_valid,
	input  wire logic [7:0]   tx_byte,
	input  wire logic         tx_first,
	input  wire logic         tx_last,
	input  wire logic [1:0]   stall_mode,
	output logic              tx_ready,
	output logic      [447:0] img,
	output logic      [7:0]   frame_len,
	output logic      [15:0]  frames
);
	logic [7:0] pos;
	logic [7:0] idx_q;

	// ==========================================
	// Capture
	// First flag restarts the index, so a short frame shows up as a wrong length
	assign pos = tx_first ? 8'h00 : idx_q;

	// Bytes only flow toward the scanner; ready may stall at random
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			tx_ready  <= 1'b0;
			idx_q     <= 8'h00;
			img       <= '0;
			frame_len <= 8'h00;
			frames    <= 16'h0000;
		end else begin
			tx_ready <= (stall_mode == 2'd0) || ($urandom_range(3) >= stall_mode);
			if (tx_valid && tx_ready) begin
				img[8*pos +: 8] <= tx_byte;
				idx_q           <= pos + 8'h01;
				if (tx_last) begin
					frame_len <= pos + 8'h01;
					frames    <= frames + 16'h0001;
				end
			end
		end
	end
endmodule : dip_sink_model

`default_nettype wire

// ---- verif/tb_top.sv ----
// Bench for the drive input image packer: registers over Wishbone, image checked against a model.
// Assumes the sink model file and the design package are compiled first.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	logic                    clk_sys, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic                    tx_valid, tx_ready, tx_first, tx_last;
	logic [7:0]              wb_adr_i, tx_byte, frame_len;
	logic [3:0]              wb_sel_i;
	logic [31:0]             wb_dat_i, wb_dat_o, rd;
	logic [255:0]            sig_pool;
	logic [447:0]            img;
	logic [15:0]             frames, exp_ro, exp_fx;
	logic [1:0]              stall_mode;
	logic [7:0]              exp_b [56];
	logic [7:0]              map_m [16];
	dip_pkg::dip_drv_state_t drv_state, st;
	int                      err_total, checked, t, k;

	dip_packer #(.CYCLES_PER_MS(4)) DUT (.clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .drv_state(drv_state),
		.sig_pool(sig_pool), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte),
		.tx_first(tx_first), .tx_last(tx_last));
	dip_sink_model SINK (.clk_sys(clk_sys), .rst_b(rst_b), .tx_valid(tx_valid), .tx_byte(tx_byte),
		.tx_first(tx_first), .tx_last(tx_last), .stall_mode(stall_mode), .tx_ready(tx_ready),
		.img(img), .frame_len(frame_len), .frames(frames));

	// ==========================================
	// Clock and hang guard
	always #50 clk_sys = ~clk_sys;

	// Whole run is a few thousand cycles; this span leaves ample margin
	initial begin
		#(100 * 60000);
		err_total++;
		$display("wrong value run time expected done seen hung");
		results();
	end

	// ==========================================
	// Tasks
	task results;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// One classic cycle; read data is taken at the edge that sees ack
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		int n;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		wb_sel_i <= 4'hF;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 100);
		rd = wb_dat_o;
		if (n >= 100) chk("bus ack", 32'h0000_0001, 32'h0000_0000);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_sys);
	endtask : wb_xfer

	task automatic put(input int o, input logic [31:0] v, input int n);
		for (int j = 0; j < n; j++) exp_b[o + j] = v[8*j +: 8];
	endtask : put

	task automatic wait_frames(input int n);
		int          lim;
		logic [15:0] tgt;
		tgt = frames + 16'(n);
		lim = 0;
		while (frames !== tgt && lim < 5000) begin
			@(posedge clk_sys);
			lim++;
		end
		if (lim >= 5000) chk("frame count", 32'(tgt), 32'(frames));
	endtask : wait_frames

	// Model of the image, least significant byte first in every field
	task automatic model(input dip_pkg::dip_drv_state_t s);
		for (int j = 0; j < 16; j++) exp_ro[j] = sig_pool[map_m[j]];
		exp_fx = {s.torque_limited, s.torque_off_active, s.stop_echo, s.direct_buffer_writing,
			s.direct_execute_fault, |s.direct_set_err, s.trigger_kind_echo, s.trigger_echo, s.alarm_flag,
			s.direct_op_accept, s.ready, s.homing_done | s.preset_done, s.start_echo, s.in_position,
			s.moving, s.stored_sequence_running};
		put(0, 32'(exp_ro), 2);
		put(2, {24'h00_0000, s.op_select}, 2);
		put(4, 32'(exp_fx), 2);
		put(6, 32'(s.alarm_code), 2);
		put(8, s.fb_pos, 4);
		put(12, s.fb_speed, 4);
		put(16, s.cmd_pos, 4);
		put(20, 32'(s.torque_mon), 2);
		put(22, 32'(s.cst_current), 2);
		put(24, s.notice_code, 4);
		put(28, 32'h0000_0000, 2);
		put(30, 32'(s.rd_id_echo), 2);
		put(32, 32'(s.rw_status), 2);
		put(34, 32'(s.wr_id_echo), 2);
		put(36, s.rd_data, 4);
		for (int j = 0; j < 4; j++) put(40 + 4*j, s.monitor[j], 4);
	endtask : model

	// ==========================================
	// Main sequence
	initial begin
		k = $urandom(12522);
		{clk_sys, rst_b, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
		{wb_adr_i, wb_sel_i, wb_dat_i, sig_pool, drv_state, stall_mode} = '0;
		{map_m[15], map_m[14], map_m[13], map_m[12], map_m[11], map_m[10], map_m[9], map_m[8]} =
			{8'h8C, 8'h8A, 8'h86, 8'h9D, 8'hA2, 8'hA1, 8'hA0, 8'h88};
		{map_m[7], map_m[6], map_m[5], map_m[4], map_m[3], map_m[2], map_m[1], map_m[0]} =
			{8'h81, 8'h87, 8'h84, 8'h90, 8'h20, 8'h42, 8'h41, 8'h40};
		repeat (4) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		wb_xfer(1'b0, 8'h00, 32'h0000_0000);
		chk("enable reset", 32'h0000_0001, rd);
		wb_xfer(1'b0, 8'h04, 32'h0000_0000);
		chk("interval reset", 32'h0000_000A, rd);
		for (k = 0; k < 16; k++) begin
			wb_xfer(1'b0, 8'h40 + 8'(4*k), 32'h0000_0000);
			chk("map reset", {24'h00_0000, map_m[k]}, rd);
		end
		wb_xfer(1'b0, 8'h20, 32'h0000_0000);
		chk("unmapped read", 32'h0000_0000, rd);
		// Interval limits at both ends
		wb_xfer(1'b1, 8'h04, 32'h0000_0000);
		wb_xfer(1'b0, 8'h04, 32'h0000_0000);
		chk("interval low", 32'h0000_0001, rd);
		wb_xfer(1'b1, 8'h04, 32'h0000_0FFF);
		wb_xfer(1'b0, 8'h04, 32'h0000_0000);
		chk("interval high", 32'h0000_0C80, rd);
		wb_xfer(1'b1, 8'h04, 32'h0000_0001);
		// Random drive states; the first pass pins the OR-type fixed bits low, the second drives preset_done alone
		for (t = 0; t < 8; t++) begin
			for (k = 0; k < $bits(st); k++) st[k] = 1'($urandom_range(1));
			if (t == 0) {st.direct_set_err, st.homing_done, st.preset_done} = '0;
			if (t == 1) {st.homing_done, st.preset_done} = 2'b01;
			stall_mode <= 2'(t % 3);
			drv_state <= st;
			for (k = 0; k < 8; k++) sig_pool[32*k +: 32] <= $urandom;
			@(posedge clk_sys);
			if (t >= 2) begin
				for (k = 0; k < 16; k++) begin
					map_m[k] = 8'($urandom_range(255));
					wb_xfer(1'b1, 8'h40 + 8'(4*k), {24'h00_0000, map_m[k]});
				end
			end
			wait_frames(2);
			model(st);
			for (k = 0; k < 56; k++) chk("image byte", {24'h00_0000, exp_b[k]}, {24'h00_0000, img[8*k +: 8]});
			chk("remote word", {16'h0000, exp_ro}, {16'h0000, img[15:8], img[7:0]});
			chk("fixed word", {16'h0000, exp_fx}, {16'h0000, img[47:40], img[39:32]});
			chk("reserved word", 32'h0000_0000, {16'h0000, img[239:224]});
			chk("frame length", 32'h0000_0038, {24'h00_0000, frame_len});
		end
		// Timer off: the frame in flight ends, no new one starts, status agrees with the sink
		wb_xfer(1'b1, 8'h00, 32'h0000_0000);
		repeat (300) @(posedge clk_sys);
		wb_xfer(1'b0, 8'h00, 32'h0000_0000);
		chk("enable off", 32'h0000_0000, rd);
		k = int'(frames);
		wb_xfer(1'b0, 8'h08, 32'h0000_0000);
		chk("status sending", 32'h0000_0000, {31'h0000_0000, rd[0]});
		chk("status frames", {16'h0000, frames}, {16'h0000, rd[31:16]});
		repeat (100) @(posedge clk_sys);
		chk("frames while off", 32'(k), {16'h0000, frames});
		results();
	end
endmodule : tb_top

`default_nettype wire
